// ---- src/tsi_pkg.sv ----
// Constants, register map and state type of the sensor init and result block
// How it works
// - Host waits out the init delay after supply is good in either mode.
// - Bus ignored during init; afterwards wait for a bus reset before talking.
// - Init reloads short address, both alert limits and offset from storage.
// - Init restores the pin configuration register from storage.
// - Init restores both configuration registers from storage.
// - Nonzero arbitration select makes address search use arbitration.
// - Fast speed bit gives overdrive unless first bus reset is standard speed.
// - Init restores memory protection bits and enforces them on user blocks.
// - Init copies key and secret words from storage into local flops.
// - Losing supply keeps all settings while the capacitor holds up.
// - Brown-out shuts off, aborts work, restarts in bus-powered operation.
// - Conversions start on command, after presence, or continuously on supply.
// - Each finished conversion updates result and status bits.
// - Format select bit in configuration one picks precision or legacy.
// - Precision result is 16-bit two's complement, LSB 0.0078125 C.
// - Legacy result is 12-bit, LSB 0.0625 C, sign in five top bits.
// - Result reads all zero before the first conversion.
// - Legacy result saturates at 07FF instead of wrapping.
// - Stored offset is added to each measurement before storing.
package tsi_pkg;
	// Timing
	localparam int CLK_HZ = 40_000_000;
	localparam int INIT_TIME_US = 100;
	localparam int INIT_CYCLES = INIT_TIME_US * (CLK_HZ / 1_000_000);
	localparam int INIT_CNT_W = 12;
	// Register byte offsets
	localparam logic [7:0] OFS_RESULT_LO = 8'h00;
	localparam logic [7:0] OFS_RESULT_HI = 8'h04;
	localparam logic [7:0] OFS_CFG1 = 8'h08;
	localparam logic [7:0] OFS_CFG2 = 8'h0c;
	localparam logic [7:0] OFS_OFFSET = 8'h10;
	localparam logic [7:0] OFS_SHORT_ADDR = 8'h14;
	localparam logic [7:0] OFS_ALERT_LO = 8'h18;
	localparam logic [7:0] OFS_ALERT_HI = 8'h1c;
	localparam logic [7:0] OFS_PIN_CFG = 8'h20;
	localparam logic [7:0] OFS_PROTECT = 8'h24;
	localparam logic [7:0] OFS_STATUS = 8'h28;
	localparam logic [7:0] OFS_CMD = 8'h2c;
	// Field positions
	localparam int CFG1_FMT_LEGACY = 0;
	localparam int CFG1_AUTO_CONV = 1;
	localparam int CFG1_CONT_CONV = 2;
	localparam int CFG2_ARB_LSB = 0;
	localparam int CFG2_FAST = 2;
	localparam int CMD_CONVERT = 0;
	localparam int ST_INIT_DONE = 0;
	localparam int ST_LINK_UP = 1;
	localparam int ST_CONV_DONE = 2;
	localparam int ST_BUS_PWR = 3;
	localparam int ST_OVERDRIVE = 4;
	localparam int ST_BUSY = 5;
	// Reset values
	localparam logic [15:0] RESULT_RST = 16'h0000;
	localparam logic [7:0] CFG_RST = 8'h00;
	// Storage word layout
	localparam int NVM_AW = 4;
	localparam logic [3:0] NVM_SHORT_ADDR = 4'h0;
	localparam logic [3:0] NVM_ALERT_LO = 4'h1;
	localparam logic [3:0] NVM_ALERT_HI = 4'h2;
	localparam logic [3:0] NVM_OFFSET = 4'h3;
	localparam logic [3:0] NVM_PIN_CFG = 4'h4;
	localparam logic [3:0] NVM_CFG1 = 4'h5;
	localparam logic [3:0] NVM_CFG2 = 4'h6;
	localparam logic [3:0] NVM_PROTECT = 4'h7;
	localparam logic [3:0] NVM_LAST = 4'hf;
	localparam int KEY_WORDS = 8;
	// Legacy and precision saturation limits
	localparam logic [15:0] LEG_MAX = 16'h07ff;
	localparam logic [15:0] LEG_MIN = 16'hf800;
	localparam logic [15:0] HP_MAX = 16'h7fff;
	localparam logic [15:0] HP_MIN = 16'h8000;
	typedef enum {TS_START, TS_LOAD, TS_WAIT_RST, TS_ACTIVE, TS_OFF} tsi_state_t;
endpackage : tsi_pkg

// ---- src/tsi_nvm_loader.sv ----
// Sequential restore of all storage words after power-up
`timescale 1ns/10ps
`default_nettype none
module tsi_nvm_loader
	import tsi_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic start,
	output logic nvm_rd_req,
	output logic [NVM_AW-1:0] nvm_addr,
	input wire logic nvm_ack,
	input wire logic [15:0] nvm_rdata,
	output logic ld_we,
	output logic [NVM_AW-1:0] ld_idx,
	output logic [15:0] ld_data,
	output logic ld_done
);
	// Request stays up until the store acknowledges each word
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			nvm_rd_req <= 1'b0;
			nvm_addr <= '0;
			ld_done <= 1'b0;
		end else if (start) begin
			nvm_rd_req <= 1'b1;
			nvm_addr <= '0;
			ld_done <= 1'b0;
		end else if (nvm_rd_req && nvm_ack) begin
			if (nvm_addr == NVM_LAST) begin
				nvm_rd_req <= 1'b0;
				ld_done <= 1'b1;
			end else begin
				nvm_addr <= nvm_addr + 4'h1;
			end
		end
	end

	// One-cycle write strobe per restored word
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ld_we <= 1'b0;
			ld_idx <= '0;
			ld_data <= '0;
		end else begin
			ld_we <= nvm_rd_req && nvm_ack && !start;
			ld_idx <= nvm_addr;
			ld_data <= nvm_rdata;
		end
	end
endmodule : tsi_nvm_loader
`default_nettype wire

// ---- src/tsi_result_fmt.sv ----
// Offset correction and result formatting, purely combinational
`timescale 1ns/10ps
`default_nettype none
module tsi_result_fmt
	import tsi_pkg::*;
(
	input wire logic [15:0] raw,
	input wire logic [15:0] offset,
	input wire logic legacy,
	output logic [15:0] result
);
	logic signed [16:0] sum;
	logic signed [13:0] leg;

	// Offset shares the precision format, so it adds before any scaling
	assign sum = $signed({raw[15], raw}) + $signed({offset[15], offset});
	// Legacy LSB is eight precision LSBs
	assign leg = sum[16:3];

	always_comb begin
		if (legacy) begin
			if (leg > 14'sd2047) begin
				result = LEG_MAX;
			end else if (leg < -14'sd2048) begin
				result = LEG_MIN;
			end else begin
				result = {{4{leg[11]}}, leg[11:0]};
			end
		end else begin
			if (sum > 17'sd32767) begin
				result = HP_MAX;
			end else if (sum < -17'sd32768) begin
				result = HP_MIN;
			end else begin
				result = sum[15:0];
			end
		end
	end
endmodule : tsi_result_fmt
`default_nettype wire

// ---- src/tsi_top.sv ----
// Power-up restore, power-mode fallback, conversion control and APB registers
`timescale 1ns/10ps
`default_nettype none
module tsi_top
	import tsi_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic nvm_rd_req,
	output logic [NVM_AW-1:0] nvm_addr,
	input wire logic nvm_ack,
	input wire logic [15:0] nvm_rdata,
	input wire logic vdd_present,
	input wire logic bod_trip,
	input wire logic wire_reset_pulse,
	input wire logic wire_reset_standard,
	input wire logic presence_done,
	input wire logic conv_cmd_pulse,
	output logic adc_start,
	input wire logic adc_done,
	input wire logic [15:0] adc_raw,
	output logic init_done,
	output logic link_enable,
	output logic overdrive_mode,
	output logic arb_search_mode,
	output logic bus_powered,
	output logic [7:0] short_addr,
	output logic [7:0] pin_cfg,
	output logic [15:0] alert_low,
	output logic [15:0] alert_high,
	input wire logic user_wr_req,
	input wire logic [1:0] user_blk,
	output logic user_wr_grant,
	input wire logic [2:0] key_idx,
	output logic [15:0] key_data
);
	tsi_state_t state_reg;
	tsi_state_t state_next;
	logic [INIT_CNT_W-1:0] init_cnt_reg;
	logic init_time_ok;
	logic ld_start;
	logic ld_we;
	logic [NVM_AW-1:0] ld_idx;
	logic [15:0] ld_data;
	logic ld_done;
	logic [7:0] cfg1_reg;
	logic [7:0] cfg2_reg;
	logic [15:0] offset_reg;
	logic [7:0] short_addr_reg;
	logic [7:0] pin_cfg_reg;
	logic [15:0] alert_lo_reg;
	logic [15:0] alert_hi_reg;
	logic [3:0] protect_reg;
	logic [15:0] key_mem [KEY_WORDS];
	logic [15:0] result_reg;
	logic [15:0] fmt_result;
	logic conv_busy_reg;
	logic conv_done_reg;
	logic cmd_conv_reg;
	logic bus_lock_reg;
	logic first_rst_seen_reg;
	logic active;
	logic conv_trigger;
	logic apb_access;
	logic apb_done;
	logic apb_wr;
	logic apb_rd;
	logic [31:0] rd_value;
	logic addr_hit;

	assign init_time_ok = (init_cnt_reg == INIT_CNT_W'(INIT_CYCLES));
	assign active = (state_reg == TS_ACTIVE);
	assign ld_start = (state_reg == TS_START);

	tsi_nvm_loader u_loader (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.start(ld_start),
		.nvm_rd_req(nvm_rd_req),
		.nvm_addr(nvm_addr),
		.nvm_ack(nvm_ack),
		.nvm_rdata(nvm_rdata),
		.ld_we(ld_we),
		.ld_idx(ld_idx),
		.ld_data(ld_data),
		.ld_done(ld_done)
	);

	tsi_result_fmt u_fmt (
		.raw(adc_raw),
		.offset(offset_reg),
		.legacy(cfg1_reg[CFG1_FMT_LEGACY]),
		.result(fmt_result)
	);

	// Power-up sequencing; brown-out overrides every state
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			TS_START: state_next = TS_LOAD;
			TS_LOAD: begin
				if (ld_done && !ld_start && init_time_ok) begin
					state_next = TS_WAIT_RST;
				end
			end
			TS_WAIT_RST: begin
				if (wire_reset_pulse) begin
					state_next = TS_ACTIVE;
				end
			end
			TS_ACTIVE: state_next = TS_ACTIVE;
			TS_OFF: begin
				if (!bod_trip) begin
					state_next = TS_START;
				end
			end
			default: state_next = TS_START;
		endcase
		if (bod_trip) begin
			state_next = TS_OFF;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= TS_START;
		end else begin
			state_reg <= state_next;
		end
	end

	// Init delay counts from the start of each power-up
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			init_cnt_reg <= '0;
		end else if (state_reg == TS_START || state_reg == TS_OFF) begin
			init_cnt_reg <= '0;
		end else if (!init_time_ok) begin
			init_cnt_reg <= init_cnt_reg + 1'b1;
		end
	end

	// Brown-out restart stays bus powered until a true reset
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_lock_reg <= 1'b0;
		end else if (bod_trip) begin
			bus_lock_reg <= 1'b1;
		end
	end

	// Settings registers: restored from storage, then writable over APB.
	// Supply loss touches none of them, so settings survive on the capacitor.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg1_reg <= CFG_RST;
			cfg2_reg <= CFG_RST;
			offset_reg <= '0;
			short_addr_reg <= '0;
			pin_cfg_reg <= '0;
			alert_lo_reg <= '0;
			alert_hi_reg <= '0;
			protect_reg <= '0;
		end else if (ld_we) begin
			case (ld_idx)
				NVM_SHORT_ADDR: short_addr_reg <= ld_data[7:0];
				NVM_ALERT_LO: alert_lo_reg <= ld_data;
				NVM_ALERT_HI: alert_hi_reg <= ld_data;
				NVM_OFFSET: offset_reg <= ld_data;
				NVM_PIN_CFG: pin_cfg_reg <= ld_data[7:0];
				NVM_CFG1: cfg1_reg <= ld_data[7:0];
				NVM_CFG2: cfg2_reg <= ld_data[7:0];
				NVM_PROTECT: protect_reg <= ld_data[3:0];
				default: ;
			endcase
		end else if (apb_wr) begin
			case (paddr)
				OFS_CFG1: cfg1_reg <= pwdata[7:0];
				OFS_CFG2: cfg2_reg <= pwdata[7:0];
				OFS_OFFSET: offset_reg <= pwdata[15:0];
				OFS_SHORT_ADDR: short_addr_reg <= pwdata[7:0];
				OFS_ALERT_LO: alert_lo_reg <= pwdata[15:0];
				OFS_ALERT_HI: alert_hi_reg <= pwdata[15:0];
				OFS_PIN_CFG: pin_cfg_reg <= pwdata[7:0];
				OFS_PROTECT: protect_reg <= pwdata[3:0];
				default: ;
			endcase
		end
	end

	// Key and secret words sit above the settings in storage
	always_ff @(posedge sys_clk) begin
		if (ld_we && ld_idx > NVM_PROTECT) begin
			key_mem[ld_idx[2:0]] <= ld_data;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			key_data <= '0;
		end else if (init_done) begin
			key_data <= key_mem[key_idx];
		end
	end

	// User block writes pass only where protection is clear
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			user_wr_grant <= 1'b0;
		end else begin
			user_wr_grant <= init_done && user_wr_req && !protect_reg[user_blk];
		end
	end

	// Trigger sources; continuous mode needs a real supply
	assign conv_trigger = active && !conv_busy_reg && !bod_trip &&
		(cfg1_reg[CFG1_AUTO_CONV] ? presence_done : (conv_cmd_pulse || cmd_conv_reg) ||
		(cfg1_reg[CFG1_CONT_CONV] && vdd_present && !bus_lock_reg));

	// Conversion handshake; brown-out abandons a running one
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			conv_busy_reg <= 1'b0;
			adc_start <= 1'b0;
		end else begin
			adc_start <= conv_trigger;
			if (!active) begin
				conv_busy_reg <= 1'b0;
			end else if (conv_trigger) begin
				conv_busy_reg <= 1'b1;
			end else if (adc_done) begin
				conv_busy_reg <= 1'b0;
			end
		end
	end

	// Result holds zero until the first conversion finishes
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			result_reg <= RESULT_RST;
		end else if (conv_busy_reg && adc_done && active) begin
			result_reg <= fmt_result;
		end
	end

	// Done flag: a finishing conversion beats a status read clear
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			conv_done_reg <= 1'b0;
		end else if (conv_busy_reg && adc_done && active) begin
			conv_done_reg <= 1'b1;
		end else if (apb_rd && paddr == OFS_STATUS) begin
			conv_done_reg <= 1'b0;
		end
	end

	// Software convert command, held in TS_ACTIVE until a trigger consumes it
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_conv_reg <= 1'b0;
		end else if (apb_wr && paddr == OFS_CMD && pwdata[CMD_CONVERT]) begin
			cmd_conv_reg <= 1'b1;
		end else if (conv_trigger || !active) begin
			cmd_conv_reg <= 1'b0;
		end
	end

	// Link side outputs
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			init_done <= 1'b0;
			link_enable <= 1'b0;
			first_rst_seen_reg <= 1'b0;
			overdrive_mode <= 1'b0;
			arb_search_mode <= 1'b0;
			bus_powered <= 1'b0;
		end else begin
			init_done <= (state_next == TS_WAIT_RST) || (state_next == TS_ACTIVE);
			link_enable <= (state_next == TS_ACTIVE);
			arb_search_mode <= (cfg2_reg[CFG2_ARB_LSB +: 2] != 2'b00);
			bus_powered <= !vdd_present || bus_lock_reg;
			if (state_reg == TS_START || state_reg == TS_OFF) begin
				first_rst_seen_reg <= 1'b0;
				overdrive_mode <= 1'b0;
			end else if (state_reg == TS_WAIT_RST && wire_reset_pulse && !first_rst_seen_reg) begin
				first_rst_seen_reg <= 1'b1;
				overdrive_mode <= cfg2_reg[CFG2_FAST] && !wire_reset_standard;
			end
		end
	end

	assign short_addr = short_addr_reg;
	assign pin_cfg = pin_cfg_reg;
	assign alert_low = alert_lo_reg;
	assign alert_high = alert_hi_reg;

	// APB: one wait state; held off entirely until restore and init delay are over
	assign apb_access = psel && penable;
	assign apb_done = apb_access && pready;
	assign apb_wr = apb_done && pwrite && !pslverr;
	assign apb_rd = apb_done && !pwrite && !pslverr;

	always_comb begin
		rd_value = '0;
		addr_hit = 1'b1;
		case (paddr)
			OFS_RESULT_LO: rd_value = {24'h000000, result_reg[7:0]};
			OFS_RESULT_HI: rd_value = {24'h000000, result_reg[15:8]};
			OFS_CFG1: rd_value = {24'h000000, cfg1_reg};
			OFS_CFG2: rd_value = {24'h000000, cfg2_reg};
			OFS_OFFSET: rd_value = {16'h0000, offset_reg};
			OFS_SHORT_ADDR: rd_value = {24'h000000, short_addr_reg};
			OFS_ALERT_LO: rd_value = {16'h0000, alert_lo_reg};
			OFS_ALERT_HI: rd_value = {16'h0000, alert_hi_reg};
			OFS_PIN_CFG: rd_value = {24'h000000, pin_cfg_reg};
			OFS_PROTECT: rd_value = {28'h0000000, protect_reg};
			OFS_STATUS: begin
				rd_value[ST_INIT_DONE] = init_done;
				rd_value[ST_LINK_UP] = link_enable;
				rd_value[ST_CONV_DONE] = conv_done_reg;
				rd_value[ST_BUS_PWR] = bus_powered;
				rd_value[ST_OVERDRIVE] = overdrive_mode;
				rd_value[ST_BUSY] = conv_busy_reg;
			end
			OFS_CMD: rd_value = '0;
			default: addr_hit = 1'b0;
		endcase
	end

	// Answer flops; pready drops right after the completing edge
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else if (apb_access && !pready && init_done) begin
			pready <= 1'b1;
			pslverr <= !addr_hit;
			prdata <= pwrite ? 32'h00000000 : rd_value;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end
endmodule : tsi_top
`default_nettype wire

// ---- verif/tsi_partner.sv ----
// Storage and converter model facing the sensor block
`timescale 1ns/10ps
`default_nettype none
module tsi_partner
	import tsi_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic nvm_rd_req,
	input wire logic [NVM_AW-1:0] nvm_addr,
	output logic nvm_ack,
	output logic [15:0] nvm_rdata,
	input wire logic adc_start,
	output logic adc_done,
	output logic [15:0] adc_raw,
	input wire logic [15:0] raw_val,
	input wire logic slow
);
	logic [15:0] mem [16] = '{16'h005a, 16'hfb00, 16'h2800, 16'h0010, 16'h00c3, 16'h0000,
		16'h0005, 16'h0005, 16'h13c5, 16'h2a5a, 16'h3c3c, 16'h4e71, 16'h5f00, 16'h6d2b,
		16'h7ab4, 16'h81ce};
	logic [3:0] n_cnt;
	logic [3:0] a_cnt;
	logic a_busy;
	// Storage answers fast or slow; idle data toggles so stale words never look valid
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			nvm_ack <= 1'b0;
			n_cnt <= 4'h0;
			nvm_rdata <= 16'h0000;
		end else if (nvm_rd_req && !nvm_ack && n_cnt >= (slow ? 4'h5 : 4'h1)) begin
			nvm_ack <= 1'b1;
			n_cnt <= 4'h0;
			nvm_rdata <= mem[nvm_addr];
		end else begin
			nvm_ack <= 1'b0;
			n_cnt <= nvm_rd_req ? n_cnt + 4'h1 : 4'h0;
			nvm_rdata <= ~nvm_rdata;
		end
	end
	// Converter finishes a few cycles after each start pulse
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			a_busy <= 1'b0;
			a_cnt <= 4'h0;
			adc_done <= 1'b0;
			adc_raw <= 16'h0000;
		end else if (adc_start) begin
			a_busy <= 1'b1;
			a_cnt <= slow ? 4'h9 : 4'h2;
			adc_done <= 1'b0;
		end else if (a_busy && a_cnt == 4'h0) begin
			a_busy <= 1'b0;
			adc_done <= 1'b1;
			adc_raw <= raw_val;
		end else begin
			a_cnt <= a_cnt - 4'h1;
			adc_done <= 1'b0;
			adc_raw <= ~adc_raw;
		end
	end
endmodule : tsi_partner
`default_nettype wire

// ---- verif/tsi_top_sva.sv ----
// Port assertions for the sensor block
`timescale 1ns/10ps
`default_nettype none
module tsi_top_sva
	import tsi_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic nvm_rd_req,
	input wire logic [NVM_AW-1:0] nvm_addr,
	input wire logic nvm_ack,
	input wire logic wire_reset_pulse,
	input wire logic wire_reset_standard,
	input wire logic bod_trip,
	input wire logic adc_start,
	input wire logic adc_done,
	input wire logic init_done,
	input wire logic link_enable,
	input wire logic overdrive_mode,
	input wire logic bus_powered,
	input wire logic user_wr_req,
	input wire logic user_wr_grant
);
	logic [11:0] up_cnt_reg;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// Cycles since release; saturates so a long run cannot wrap it
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			up_cnt_reg <= 12'h000;
		end else if (up_cnt_reg != 12'hfff) begin
			up_cnt_reg <= up_cnt_reg + 12'h001;
		end
	end
	a_init_delay_met: assert property ($rose(init_done) |-> up_cnt_reg >= 12'(INIT_CYCLES))
		else $error("init done before delay");
	a_link_after_reset: assert property ($rose(link_enable) |-> init_done && $past(wire_reset_pulse))
		else $error("link up without bus reset");
	a_std_no_fast: assert property ($rose(link_enable) && $past(wire_reset_standard) |-> !overdrive_mode)
		else $error("overdrive after standard reset");
	a_load_hold: assert property (nvm_rd_req && !nvm_ack |=> nvm_rd_req && $stable(nvm_addr))
		else $error("storage request dropped");
	a_ready_gated: assert property (pready |-> init_done)
		else $error("register answer before init");
	a_load_first: assert property (init_done |-> !nvm_rd_req)
		else $error("init done while loading");
	a_conv_linked: assert property (adc_start |-> link_enable ##1 !adc_start)
		else $error("conversion start unlinked");
	a_grant_cause: assert property (user_wr_grant |-> $past(user_wr_req))
		else $error("grant without request");
	// Supply loss alone may come and go; only a brown-out pins bus power
	a_bp_sticky: assert property (bod_trip |-> ##2 bus_powered [*8])
		else $error("bus powered lost");
	a_bod_quiet: assert property (bod_trip [*2] |-> !adc_start)
		else $error("conversion during brown-out");
	c_link: cover property ($rose(link_enable));
	c_conv: cover property (adc_done && link_enable);
	c_err: cover property (pready && pslverr);
	c_bod: cover property ($rose(bus_powered));
endmodule : tsi_top_sva
bind tsi_top tsi_top_sva u_sva (.*);
`default_nettype wire

// ---- verif/test_temp_sensor_init_and_result.sv ----
// Self-checking bench for restore, link, conversions and brown-out
`timescale 1ns/10ps
`default_nettype none
module test_temp_sensor_init_and_result;
	import tsi_pkg::*;
	logic sys_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, nvm_rd_req, nvm_ack, adc_start, adc_done, user_wr_grant;
	logic init_done, link_enable, overdrive_mode, arb_search_mode, bus_powered;
	logic [7:0] short_addr, pin_cfg;
	logic [NVM_AW-1:0] nvm_addr;
	logic [15:0] nvm_rdata, adc_raw, alert_low, alert_high, key_data;
	logic vdd_present = 1'b1, bod_trip = 1'b0, wire_reset_pulse = 1'b0;
	logic wire_reset_standard = 1'b0, presence_done = 1'b0, conv_cmd_pulse = 1'b0;
	logic user_wr_req = 1'b0, slow = 1'b0;
	logic [1:0] user_blk = 2'h0;
	logic [2:0] key_idx = 3'h0;
	logic [15:0] raw_val = 16'h0000;
	int err_count = 0, n_compared = 0, n_start = 0;
	logic [7:0] ofs [8] = '{OFS_SHORT_ADDR, OFS_ALERT_LO, OFS_ALERT_HI, OFS_OFFSET,
		OFS_PIN_CFG, OFS_CFG1, OFS_CFG2, OFS_PROTECT};
	logic [15:0] corner [5] = '{16'h0c80, 16'h7fff, 16'hf480, 16'h8000, 16'h4b00};
	tsi_top u_dut (.*);
	tsi_partner u_nvm (.*);
	initial forever #12.5 sys_clk = ~sys_clk;
	// Counts conversion starts so ignored triggers can be seen
	always @(posedge sys_clk) if (adc_start === 1'b1) n_start <= n_start + 1;
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic stop_test;
		$display("Compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : stop_test
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : tick
	// Bounded wait: 0 init done, 1 conversion done, 2 bus ready
	task automatic waitfor(input int w);
		int i;
		i = 0;
		do begin
			@(posedge sys_clk);
			i++;
		end while ((w == 0 ? init_done : w == 1 ? adc_done : pready) !== 1'b1 && i < 20000);
		if (i >= 20000) begin
			err_count++;
			stop_test();
		end
	endtask : waitfor
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		waitfor(2);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Offset first in precision units, then legacy shift and clamp
	function automatic logic [15:0] fmt(input logic [15:0] raw, input logic [15:0] off,
		input logic leg);
		int s;
		s = $signed(raw) + $signed(off);
		s = s > 32767 ? 32767 : s < -32768 ? -32768 : s;
		if (leg) begin
			s = s >>> 3;
			s = s > 2047 ? 2047 : s < -2048 ? -2048 : s;
		end
		return 16'(s);
	endfunction : fmt
	// Trigger kinds: 0 command pulse, 1 presence, 2 command register
	task automatic trig(input int how);
		logic [31:0] rd;
		logic e;
		if (how == 2) begin
			apb(1'b1, OFS_CMD, 32'h1, rd, e);
		end else begin
			@(posedge sys_clk);
			conv_cmd_pulse <= (how == 0);
			presence_done <= (how == 1);
			@(posedge sys_clk);
			conv_cmd_pulse <= 1'b0;
			presence_done <= 1'b0;
		end
	endtask : trig
	task automatic conv(input int how, input logic [15:0] raw, input logic leg);
		logic [31:0] lo, hi;
		logic e;
		raw_val <= raw;
		slow <= 1'($urandom);
		trig(how);
		waitfor(1);
		apb(1'b0, OFS_RESULT_LO, 32'h0, lo, e);
		apb(1'b0, OFS_RESULT_HI, 32'h0, hi, e);
		check("result", {hi[7:0], lo[7:0]}, fmt(raw, u_nvm.mem[3], leg));
		apb(1'b0, OFS_STATUS, 32'h0, lo, e);
		check("conv done flag", lo[ST_CONV_DONE], 32'h1);
	endtask : conv
	task automatic linkup(input logic std);
		@(posedge sys_clk);
		wire_reset_pulse <= 1'b1;
		wire_reset_standard <= std;
		@(posedge sys_clk);
		wire_reset_pulse <= 1'b0;
		tick(2);
	endtask : linkup
	initial begin
		#2500000;
		err_count++;
		stop_test();
	end
	initial begin
		logic [31:0] rd;
		logic e;
		int s0;
		void'($urandom(52222));
		tick(2);
		rst_n <= 1'b1;
		// An access issued at once stalls until restore and delay are over
		apb(1'b0, OFS_RESULT_HI, 32'h0, rd, e);
		check("ready after init", init_done, 32'h1);
		check("result before conv", rd, 32'h0);
		for (int k = 0; k < 8; k++) begin
			apb(1'b0, ofs[k], 32'h0, rd, e);
			check("restored reg", rd, {16'h0, u_nvm.mem[k]});
		end
		check("short addr", short_addr, u_nvm.mem[0]);
		check("alert low", alert_low, u_nvm.mem[1]);
		check("alert high", alert_high, u_nvm.mem[2]);
		check("pin cfg", pin_cfg, u_nvm.mem[4]);
		check("arbitration", arb_search_mode, 32'h1);
		for (int k = 0; k < 8; k++) begin
			key_idx <= 3'(k);
			tick(3);
			check("key word", key_data, u_nvm.mem[8 + k]);
		end
		for (int k = 0; k < 4; k++) begin
			user_wr_req <= 1'b1;
			user_blk <= 2'(k);
			tick(3);
			check("write grant", user_wr_grant, !u_nvm.mem[7][k]);
		end
		user_wr_req <= 1'b0;
		apb(1'b0, 8'h30, 32'h0, rd, e);
		check("unmapped error", e, 32'h1);
		// Commands are ignored until the first bus reset
		s0 = n_start;
		trig(0);
		tick(10);
		check("no conv unlinked", n_start, s0);
		linkup(1'b0);
		check("link up", link_enable, 32'h1);
		check("overdrive", overdrive_mode, u_nvm.mem[6][2]);
		// Zero arbitration field must turn arbitration search off again
		apb(1'b1, OFS_CFG2, 32'h4, rd, e);
		tick(2);
		check("arb off", arb_search_mode, 32'h0);
		// Corner samples in both formats, then random ones
		for (int f = 0; f < 2; f++) begin
			apb(1'b1, OFS_CFG1, 32'(f), rd, e);
			for (int k = 0; k < 11; k++) begin
				conv(2 * (k % 2), k < 5 ? corner[k] : 16'($urandom), f[0]);
			end
		end
		apb(1'b1, OFS_CFG1, 32'h2, rd, e);
		s0 = n_start;
		trig(0);
		tick(10);
		check("cmd ignored auto", n_start, s0);
		conv(1, 16'hff80, 1'b0);
		// Supply powered continuous mode converts with no trigger
		s0 = n_start;
		apb(1'b1, OFS_CFG1, 32'h4, rd, e);
		tick(100);
		check("continuous", n_start > s0 + 2, 32'h1);
		apb(1'b1, OFS_CFG1, 32'h0, rd, e);
		tick(30);
		// Supply loss alone: a written setting must survive on the capacitor
		apb(1'b1, OFS_SHORT_ADDR, 32'ha5, rd, e);
		vdd_present <= 1'b0;
		tick(5);
		check("supply lost", bus_powered, 32'h1);
		check("addr kept", short_addr, 32'ha5);
		vdd_present <= 1'b1;
		tick(3);
		check("supply back", bus_powered, 32'h0);
		// Brown-out: shut off, restore again, come back bus powered
		vdd_present <= 1'b0;
		bod_trip <= 1'b1;
		tick(5);
		check("bus powered", bus_powered, 32'h1);
		bod_trip <= 1'b0;
		tick(2);
		waitfor(0);
		check("addr restored", short_addr, u_nvm.mem[0]);
		linkup(1'b1);
		check("standard speed", overdrive_mode, 32'h0);
		vdd_present <= 1'b1;
		s0 = n_start;
		apb(1'b1, OFS_CFG1, 32'h4, rd, e);
		tick(60);
		check("no continuous bod", n_start, s0);
		stop_test();
	end
endmodule : test_temp_sensor_init_and_result
`default_nettype wire
